// *** src/sgps_top.sv ***
// Sine generator core with stop-at-zero-crossing hold and resume.
// Assumes the controller drives the serial word, the transfer strobe
// and the tri-level stop pin; all of them are asynchronous pins.
//
// Summary of operation
// - Hold needs stop low, zero word, strobe high
// - Run on to next crossing, then freeze
// - Nonzero latched word resumes from stop point
// - After 1.5 periods output rests near zero
// - Output updates on divided reference clock enable
// - 16-bit word, up to 50 kHz, 1 Hz steps
`timescale 1ns/1ps
module sgps_top #(
    parameter int UPD_DIV = sgps_pkg::UPDATE_DIV
) (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic NRST_IN,
    // Serial frequency shift register pins
    input wire logic SHIFT_CLK_IN,
    input wire logic SHIFT_DATA_IN,
    // Strobe and tri-level stop pins
    input wire logic TRANSFER_STROBE_IN,
    input wire logic [1:0] TRI_LEVEL_STOP_PIN_IN,
    // Generator output
    output logic signed [11:0] SINE_OUT,
    output logic UPDATE_OUT,
    output sgps_pkg::sgps_status_t STATUS_OUT
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] meta;
    logic [4:0] sync;
    logic shift_clk_d;

    // Two flops per pin; only the second stage is read by logic
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            meta <= 5'h00;
            sync <= 5'h00;
            shift_clk_d <= 1'b0;
        end else begin
            meta <= {TRI_LEVEL_STOP_PIN_IN, TRANSFER_STROBE_IN,
                     SHIFT_DATA_IN, SHIFT_CLK_IN};
            sync <= meta;
            shift_clk_d <= sync[0];
        end
    end

    logic shift_edge;
    logic strobe;
    logic [1:0] stop_lvl;
    assign shift_edge = sync[0] & ~shift_clk_d;
    assign strobe = sync[2];
    assign stop_lvl = sync[4:3];

    // ------------------------------------------------------------
    // Shift register and data latch
    // ------------------------------------------------------------
    logic [15:0] shift_word;
    logic [15:0] latch_word;
    logic strobe_d;
    logic strobe_fall;
    logic loaded;

    // Serial word, most significant bit first
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            shift_word <= 16'h0000;
        end else if (shift_edge) begin
            shift_word <= {shift_word[14:0], sync[1]};
        end
    end

    // Strobe fall transfers the word; shifting under a high strobe
    // stays invisible, so the fall alone times each start
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            strobe_d <= 1'b0;
            latch_word <= 16'h0000;
            loaded <= 1'b0;
        end else begin
            strobe_d <= strobe;
            loaded <= strobe_fall && (shift_word != 16'h0000);
            if (strobe_fall) begin
                latch_word <= shift_word;
            end
        end
    end
    assign strobe_fall = strobe_d & ~strobe;

    // ------------------------------------------------------------
    // Update rate divider
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic upd;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            div_cnt <= 8'h00;
        end else if (div_cnt == 8'(UPD_DIV - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign upd = (div_cnt == 8'(UPD_DIV - 1));

    // ------------------------------------------------------------
    // Hold sequencing
    // ------------------------------------------------------------
    sgps_pkg::sgps_state_t state;
    sgps_pkg::sgps_state_t next_state;
    logic hold_cond;
    logic pdown;
    logic [15:0] run_word;
    logic [21:0] acc;
    logic [21:0] next_acc;
    logic [22:0] sum;
    logic wrap;
    logic cross_half;
    logic hold_neg;

    assign hold_cond = (stop_lvl == sgps_pkg::STOP_AT_VSS)
        && (shift_word == 16'h0000) && strobe;
    assign pdown = (stop_lvl == sgps_pkg::STOP_AT_VDD);

    // word clamped to the top output frequency
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            run_word <= 16'h0000;
        end else if (latch_word > sgps_pkg::MAX_WORD) begin
            run_word <= sgps_pkg::MAX_WORD;
        end else if (latch_word != 16'h0000 || state == sgps_pkg::SGPS_RUN)
        begin
            run_word <= latch_word;
        end
    end

    // Phase step and crossing detection; no divider needed
    always_comb begin
        sum = {1'b0, acc} + {7'h00, run_word};
        wrap = (sum >= {1'b0, sgps_pkg::ACC_MOD});
        cross_half = (acc < sgps_pkg::ACC_HALF)
            && (sum >= {1'b0, sgps_pkg::ACC_HALF});
        if (wrap) begin
            next_acc = 22'(sum - {1'b0, sgps_pkg::ACC_MOD});
        end else begin
            next_acc = sum[21:0];
        end
    end

    // State transitions
    always_comb begin
        next_state = state;
        case (state)
            sgps_pkg::SGPS_RUN: begin
                if (hold_cond) begin
                    next_state = sgps_pkg::SGPS_ARMED;
                end
            end
            sgps_pkg::SGPS_ARMED: begin
                if (upd && !pdown && (wrap || cross_half)) begin
                    next_state = sgps_pkg::SGPS_FROZEN;
                end
            end
            sgps_pkg::SGPS_FROZEN: begin
                // new nonzero word releases the hold
                if (loaded) begin
                    next_state = sgps_pkg::SGPS_RUN;
                end
            end
            default: next_state = sgps_pkg::SGPS_RUN;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            state <= sgps_pkg::SGPS_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Accumulator: parks exactly on the crossing so resume continues
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            acc <= 22'h00_0000;
            hold_neg <= 1'b0;
        end else if (upd && !pdown && state != sgps_pkg::SGPS_FROZEN) begin
            if (state == sgps_pkg::SGPS_ARMED && wrap) begin
                acc <= 22'h00_0000;
                hold_neg <= 1'b0;
            end else if (state == sgps_pkg::SGPS_ARMED && cross_half) begin
                acc <= sgps_pkg::ACC_HALF;
                hold_neg <= 1'b1;
            end else begin
                acc <= next_acc;
            end
        end
    end

    // ------------------------------------------------------------
    // Output shaping
    // ------------------------------------------------------------
    logic [63:0] ph_prod;
    logic [21:0] phase;
    logic signed [11:0] shaped;

    // Scale accumulator to a binary fraction of a cycle
    assign ph_prod = {42'h0, acc} * sgps_pkg::PHASE_SCALE;
    assign phase = ph_prod[43:22];

    sgps_shaper #(
        .PH_W(sgps_pkg::ACC_W),
        .OUT_W(sgps_pkg::SAMPLE_W)
    ) u_shaper (
        .clk(SYS_CLK_IN),
        .nrst(NRST_IN),
        .phase(phase),
        .sample(shaped)
    );

    // frozen output rests just beside zero
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            SINE_OUT <= 12'sh000;
        end else if (pdown) begin
            SINE_OUT <= 12'sh000;
        end else if (state == sgps_pkg::SGPS_FROZEN) begin
            SINE_OUT <= hold_neg ? -$signed(sgps_pkg::HOLD_OFS)
                                 : $signed(sgps_pkg::HOLD_OFS);
        end else begin
            SINE_OUT <= shaped;
        end
    end

    // Status pins and update tick
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            STATUS_OUT <= '0;
            UPDATE_OUT <= 1'b0;
        end else begin
            STATUS_OUT.frozen <= (state == sgps_pkg::SGPS_FROZEN);
            STATUS_OUT.armed <= (state == sgps_pkg::SGPS_ARMED);
            STATUS_OUT.powered_down <= pdown;
            UPDATE_OUT <= upd;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Delay from the second checked idle cycle to the next enable
    localparam int A_GAP = UPD_DIV - 2;

    sequence s_armed_at_cross;
        state == sgps_pkg::SGPS_ARMED && upd && !pdown
            && (wrap || cross_half);
    endsequence

    sequence s_frozen_parked;
        state == sgps_pkg::SGPS_FROZEN
            && (acc == 22'h00_0000 || acc == sgps_pkg::ACC_HALF);
    endsequence

    property p_hold_entry;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        state == sgps_pkg::SGPS_RUN && !hold_cond
            |=> state != sgps_pkg::SGPS_ARMED;
    endproperty
    a_hold_entry: assert property (p_hold_entry)
        else $error("hold armed without all conditions");

    property p_freeze_cross;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        s_armed_at_cross |=> s_frozen_parked;
    endproperty
    a_freeze_cross: assert property (p_freeze_cross)
        else $error("did not freeze on the crossing");

    property p_freeze_only_cross;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        $rose(state == sgps_pkg::SGPS_FROZEN)
            |-> $past(state == sgps_pkg::SGPS_ARMED && (wrap || cross_half));
    endproperty
    a_freeze_only_cross: assert property (p_freeze_only_cross)
        else $error("froze away from a crossing");

    property p_resume;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        state == sgps_pkg::SGPS_FROZEN && loaded
            |=> state == sgps_pkg::SGPS_RUN && $stable(acc);
    endproperty
    a_resume: assert property (p_resume)
        else $error("no resume from parked phase");

    property p_held;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        state == sgps_pkg::SGPS_FROZEN && !loaded
            |=> state == sgps_pkg::SGPS_FROZEN && $stable(acc);
    endproperty
    a_held: assert property (p_held)
        else $error("hold released without a new word");

    property p_rest_level;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (state == sgps_pkg::SGPS_FROZEN && !pdown)[*2]
            |-> SINE_OUT == (hold_neg ? -$signed(sgps_pkg::HOLD_OFS)
                                      : $signed(sgps_pkg::HOLD_OFS));
    endproperty
    a_rest_level: assert property (p_rest_level)
        else $error("held output not beside zero");

    property p_upd_gap;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        upd |=> !upd[*2] ##A_GAP upd;
    endproperty
    a_upd_gap: assert property (p_upd_gap)
        else $error("update enable spacing wrong");

    property p_word_range;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        run_word <= sgps_pkg::MAX_WORD && acc < sgps_pkg::ACC_MOD;
    endproperty
    a_word_range: assert property (p_word_range)
        else $error("word or phase out of range");

endmodule : sgps_top

// *** src/sgps_pkg.sv ***
// Shared constants and carrier types for the sine generator sequencer.
// Assumes a single 100 MHz system clock and no software register access.
package sgps_pkg;

    // ------------------------------------------------------------
    // Clocking and update rate
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    // Output update rate (master 12 MHz divided by four)
    localparam int UPDATE_HZ = 3_000_000;
    // Longest period rounds down to whole cycles
    localparam int UPDATE_DIV = CLK_HZ / UPDATE_HZ;

    // ------------------------------------------------------------
    // Frequency word and phase
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    // Highest output frequency in Hz; one word step is 1 Hz
    localparam logic [15:0] MAX_WORD = 16'hC350;
    localparam int ACC_W = 22;
    // One full cycle equals UPDATE_HZ accumulator counts: 1 Hz steps
    localparam logic [21:0] ACC_MOD = 22'h2D_C6C0;
    localparam logic [21:0] ACC_HALF = 22'h16_E360;
    // Maps one full cycle of counts onto the whole binary phase range
    localparam logic [63:0] PHASE_SCALE = 64'h0000_0000_0059_7A7E;

    // ------------------------------------------------------------
    // Output sample
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 12;
    // Held level next to zero, roughly peak over 256
    localparam logic [11:0] HOLD_OFS = 12'h004;

    // ------------------------------------------------------------
    // Tri-level stop pin encoding
    // ------------------------------------------------------------
    localparam logic [1:0] STOP_AT_VSS = 2'b00;
    localparam logic [1:0] STOP_MID = 2'b01;
    localparam logic [1:0] STOP_AT_VDD = 2'b10;

    typedef enum logic [1:0] {
        SGPS_RUN,
        SGPS_ARMED,
        SGPS_FROZEN
    } sgps_state_t;

    // Generator status as seen at the pins
    typedef struct packed {
        logic frozen;
        logic armed;
        logic powered_down;
    } sgps_status_t;

endpackage : sgps_pkg

// *** src/sgps_shaper.sv ***
// Sine shaper: turns a phase into a signed sample, registered.
// Assumes phase updates on the same clock; parabolic approximation.
`timescale 1ns/1ps
module sgps_shaper #(
    parameter int PH_W = 22,
    parameter int OUT_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Phase in, sample out
    input wire logic [PH_W-1:0] phase,
    output logic signed [OUT_W-1:0] sample
);

    logic [PH_W-2:0] frac;
    logic [PH_W-1:0] rest;
    logic [2*PH_W-1:0] prod;
    logic [OUT_W-1:0] mag;

    // Half-cycle parabola 4q(1-q): cheap, about 6% off a true sine
    always_comb begin
        frac = phase[PH_W-2:0];
        rest = {1'b1, {(PH_W-1){1'b0}}} - {1'b0, frac};
        prod = {{(PH_W+1){1'b0}}, frac} * {{PH_W{1'b0}}, rest};
        mag = {1'b0, prod[2*PH_W-4 -: OUT_W-1]};
    end

    // Registered sample; upper half of the cycle is negative
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sample <= '0;
        end else if (phase[PH_W-1]) begin
            sample <= -$signed(mag);
        end else begin
            sample <= $signed(mag);
        end
    end

endmodule : sgps_shaper

// *** sim/sgps_ctrl_model.sv ***
// Controller model: shifts words, drives strobe and tri-level stop pin.
// Assumes the generator resynchronises every pin to its own clock.
`timescale 1ns/1ps
module sgps_ctrl_model #(
    parameter int UPD_DIV = 33
) (
    // Clock and watched sample
    input wire logic clk,
    input wire logic signed [11:0] sine_in,
    // Pins to the generator
    output logic shift_clk_out,
    output logic shift_data_out,
    output logic strobe_out,
    output logic [1:0] stop_pin_out
);
    // ------------------------------------------
    // Pin drivers
    // ------------------------------------------
    // Idle: run level, strobe low
    initial begin
        shift_clk_out = 1'b0;
        shift_data_out = 1'b0;
        strobe_out = 1'b0;
        stop_pin_out = sgps_pkg::STOP_MID;
    end

    function automatic int per(input logic [15:0] w);
        return (sgps_pkg::UPDATE_HZ / int'(w)) * UPD_DIV;
    endfunction : per

    // Levels held 4 clocks, above the 3 the synchroniser needs
    task automatic shift_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            shift_data_out <= w[i];
            repeat (4) @(posedge clk);
            shift_clk_out <= 1'b1;
            repeat (4) @(posedge clk);
            shift_clk_out <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask : shift_word

    task automatic set_strobe(input logic v);
        @(posedge clk);
        strobe_out <= v;
    endtask : set_strobe

    task automatic set_stop(input logic [1:0] v);
        @(posedge clk);
        stop_pin_out <= v;
    endtask : set_stop

    task automatic strobe_when_low(input int limit);
        int n;
        n = 0;
        @(posedge clk);
        while (sine_in[11] !== 1'b1 && n < limit) begin
            @(posedge clk);
            n++;
        end
        strobe_out <= 1'b1;
    endtask : strobe_when_low

    // word in, strobe low, wait, zeros
    task automatic initialise(input logic [15:0] w);
        set_strobe(1'b1);
        set_stop(sgps_pkg::STOP_MID);
        shift_word(w);
        set_strobe(1'b0);
        repeat (per(w)) @(posedge clk);
        shift_word(16'h0000);
        set_stop(sgps_pkg::STOP_AT_VSS);
        strobe_when_low(per(w));
        // rest one and a half periods
        repeat (per(w) * 3 / 2) @(posedge clk);
    endtask : initialise
endmodule : sgps_ctrl_model

// *** sim/tb_top.sv ***
// Testbench: reset, update rate, init, hold, synced start, period.
// Assumes the controller model drives every generator pin but clock and reset.
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------
    // Signals, instances and checking
    // ------------------------------------------
    localparam int DIV = 33;
    logic clk;
    logic nrst;
    logic sck;
    logic sdat;
    logic strobe;
    logic [1:0] stop_pin;
    logic signed [11:0] sine;
    logic upd;
    sgps_pkg::sgps_status_t status;
    int err_total;
    int num_checks;
    integer seed;
    int meas;
    logic [15:0] w2;
    string name_q[$];
    logic [31:0] exp_q[$];
    int sel_q[$];
    event sample_ev;

    sgps_top #(.UPD_DIV(DIV)) uut (
        .SYS_CLK_IN(clk), .NRST_IN(nrst),
        .SHIFT_CLK_IN(sck), .SHIFT_DATA_IN(sdat),
        .TRANSFER_STROBE_IN(strobe), .TRI_LEVEL_STOP_PIN_IN(stop_pin),
        .SINE_OUT(sine), .UPDATE_OUT(upd), .STATUS_OUT(status)
    );
    sgps_ctrl_model #(.UPD_DIV(DIV)) u_ctrl (
        .clk(clk), .sine_in(sine), .shift_clk_out(sck),
        .shift_data_out(sdat), .strobe_out(strobe),
        .stop_pin_out(stop_pin)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Note an expectation; the observer samples the output
    task automatic note(input string what, input logic [31:0] exp,
                        input int sel);
        name_q.push_back(what);
        exp_q.push_back(exp);
        sel_q.push_back(sel);
        -> sample_ev;
        #1;
    endtask : note

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // Observer: pairs each sampled output with the oldest note
    initial begin : observe
        logic [31:0] seen;
        forever begin
            @(sample_ev);
            while (exp_q.size() > 0) begin
                case (sel_q[0])
                    0: seen = 32'(sine);
                    1: seen = {31'h0, status.frozen};
                    2: seen = {31'h0, status.armed};
                    4: seen = {31'h0, status.powered_down};
                    default: seen = meas;
                endcase
                check(name_q.pop_front(), seen, exp_q.pop_front());
                void'(sel_q.pop_front());
            end
        end
    end

    // Watchdog, sized well above the whole sequence
    initial begin
        repeat (100_000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    task automatic gap();
        int n;
        n = 0;
        while (upd !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        meas = 0;
        do begin
            @(posedge clk);
            #1;
            meas++;
        end while (upd !== 1'b1 && meas < 100);
        note("update spacing", 32'(DIV), 3);
    endtask : gap

    // Updates between two rising crossings; one off allowed
    task automatic period(input int exp_upd);
        int k;
        int n;
        logic signed [11:0] prev;
        k = 0;
        n = 0;
        meas = 0;
        prev = sine;
        while (k < 2 && n < 12000) begin
            @(posedge clk);
            #1;
            n++;
            if (k == 1 && upd === 1'b1) meas++;
            if (prev <= 0 && sine > 0) k++;
            prev = sine;
        end
        meas = (meas >= exp_upd - 1 && meas <= exp_upd + 1) ? 1 : 0;
        note("period", 32'h1, 3);
    endtask : period

    // Main sequence
    initial begin
        nrst = 1'b0;
        seed = 32'hb188;
        err_total = 0;
        num_checks = 0;
        meas = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        note("sine", 32'h0, 0);
        note("frozen", 32'h0, 1);
        note("powered down", 32'h0, 4);
        gap();
        $display("test reset and update rate done");
        u_ctrl.initialise(sgps_pkg::MAX_WORD);
        note("frozen", 32'h1, 1);
        note("sine", 32'(sgps_pkg::HOLD_OFS), 0);
        repeat (4000) @(posedge clk);
        #1;
        note("sine", 32'(sgps_pkg::HOLD_OFS), 0);
        $display("test init and hold done");
        w2 = 16'(20000 + $unsigned($random(seed)) % 30001);
        u_ctrl.shift_word(w2);
        #1;
        note("frozen", 32'h1, 1);
        u_ctrl.set_strobe(1'b0);
        meas = 0;
        // Release may show zero samples, for up to one update interval, before the first rising one
        while ((sine === sgps_pkg::HOLD_OFS || sine === 12'sh000)
               && meas < 200) begin
            @(posedge clk);
            #1;
            meas++;
        end
        meas = (meas <= DIV + 8) ? 1 : 0;
        note("start delay", 32'h1, 3);
        meas = (sine > 12'sd4) ? 1 : 0;
        note("rising start", 32'h1, 3);
        // Random run level: both 01 and 11 must keep running
        u_ctrl.set_stop(sgps_pkg::STOP_MID | {w2[0], 1'b0});
        period(sgps_pkg::UPDATE_HZ / int'(w2));
        u_ctrl.set_strobe(1'b1);
        u_ctrl.shift_word(16'hFFFF);
        u_ctrl.set_strobe(1'b0);
        period(sgps_pkg::UPDATE_HZ / int'(sgps_pkg::MAX_WORD));
        $display("test start and period done");
        // Zero word and strobe high, stop pin at run
        u_ctrl.set_strobe(1'b1);
        u_ctrl.shift_word(16'h0000);
        repeat (4 * DIV) @(posedge clk);
        #1;
        note("armed", 32'h0, 2);
        // Reload a running word, then zeros under a low strobe
        u_ctrl.shift_word(sgps_pkg::MAX_WORD);
        u_ctrl.set_strobe(1'b0);
        u_ctrl.shift_word(16'h0000);
        // Stop low and zero word, strobe low
        u_ctrl.set_stop(sgps_pkg::STOP_AT_VSS);
        repeat (4 * DIV) @(posedge clk);
        #1;
        note("armed", 32'h0, 2);
        note("frozen", 32'h0, 1);
        u_ctrl.set_strobe(1'b1);
        repeat (2100) @(posedge clk);
        #1;
        note("frozen", 32'h1, 1);
        // Power-down level parks the output at zero
        u_ctrl.set_stop(sgps_pkg::STOP_AT_VDD);
        repeat (8) @(posedge clk);
        #1;
        note("sine", 32'h0, 0);
        note("powered down", 32'h1, 4);
        $display("test hold conditions done");
        give_verdict();
    end
endmodule : tb_top
